/* core/uarx_receiver.sv */
// Asynchronous serial receive front end: sampling, voting, framing, buffer
//
// Functional notes
// - Receiver off empties the receive buffer completely.
// - Sample at 16x baud, 8x in double speed.
// - Falling edge on idle line starts detection.
// - Validate start on samples 8-10 or 4-6.
// - Majority high rejects start as noise spike.
// - Resynchronise bit timing on every valid start.
// - Sixteen or eight sample states per bit.
// - Each bit decided by three-sample majority vote.
// - Voting starts at sample 8 or 4.
// - Recover through first stop bit, ignore others.
// - Stop bit voted zero sets frame error.
// - New start accepted right after stop voting.
// - Complete flag high exactly while buffer holds data.
// - Frame error stored and read with its character.
// - Turning receiver off aborts reception at once.
`timescale 1ns/10ps
`default_nettype none
`include "uarx_regs.svh"

module uarx_receiver
    import uarx_pkg::*;
#(
    parameter int FIFO_DEPTH = `UARX_FIFO_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_serial_receive_line,
    input wire logic i_receiver_on,
    input wire logic i_double_speed_select,
    input wire logic [`UARX_DIV_W-1:0] i_baud_divisor,
    input wire logic [`UARX_BITCNT_W-1:0] i_frame_bits,
    input wire logic i_rx_read,
    output logic [`UARX_FRAME_MAX-1:0] o_rx_data_location,
    output logic o_frame_error_flag,
    output logic o_rx_complete_flag,
    output logic o_data_overrun
);
    generate
        if (FIFO_DEPTH < 2) begin : g_bad
            $error("uarx_receiver: FIFO_DEPTH too small");
        end
    endgenerate

    function automatic logic majority(input logic a, input logic b, input logic c);
        majority = (a & b) | (a & c) | (b & c);
    endfunction

    // Line synchroniser
    logic sync1_r;
    logic rxd_s_r;

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_r <= 1'b1;
            rxd_s_r <= 1'b1;
        end else begin
            sync1_r <= i_serial_receive_line;
            rxd_s_r <= sync1_r;
        end
    end

    // Receiver state
    uarx_state_t state_r;
    uarx_state_t state_nxt;
    logic [`UARX_DIV_W-1:0] div_r;
    logic [`UARX_DIV_W-1:0] div_nxt;
    logic [4:0] samp_r;
    logic [4:0] samp_nxt;
    logic [1:0] vote_r;
    logic [1:0] vote_nxt;
    logic last_r;
    logic last_nxt;
    logic [`UARX_BITCNT_W-1:0] bitcnt_r;
    logic [`UARX_BITCNT_W-1:0] bitcnt_nxt;
    logic [`UARX_FRAME_MAX-1:0] shreg_r;
    logic [`UARX_FRAME_MAX-1:0] shreg_nxt;
    uarx_char_t hold_r;
    uarx_char_t hold_nxt;
    logic hold_valid_r;
    logic hold_valid_nxt;
    logic overrun_r;
    logic overrun_nxt;

    logic tick_w;
    logic [4:0] spb_w;
    logic [4:0] vfirst_w;
    logic [4:0] n_w;
    logic vote_pt_w;
    logic maj_w;
    logic wrap_w;
    logic start_det_w;
    logic done_w;
    logic fifo_ready_w;
    uarx_char_t fifo_out_w;

    assign tick_w = (div_r == '0);
    assign spb_w = i_double_speed_select ? `UARX_SPB_DOUBLE : `UARX_SPB_NORMAL;
    assign vfirst_w = i_double_speed_select ? `UARX_VOTE_DOUBLE : `UARX_VOTE_NORMAL;
    assign n_w = (samp_r >= spb_w) ? `UARX_FIRST_SAMPLE : samp_r + 5'h01;
    assign wrap_w = tick_w && (samp_r >= spb_w);
    assign vote_pt_w = tick_w && (n_w == vfirst_w + `UARX_VOTE_LAST);
    assign maj_w = majority(vote_r[1], vote_r[0], rxd_s_r);
    assign start_det_w = (state_r == UARX_ST_IDLE) && tick_w && last_r && !rxd_s_r;
    assign done_w = (state_r == UARX_ST_STOP) && vote_pt_w;

    always_comb begin
        state_nxt = state_r;
        div_nxt = tick_w ? i_baud_divisor : div_r - 1'b1;
        samp_nxt = samp_r;
        vote_nxt = vote_r;
        last_nxt = tick_w ? rxd_s_r : last_r;
        bitcnt_nxt = bitcnt_r;
        shreg_nxt = shreg_r;
        hold_nxt = hold_r;
        hold_valid_nxt = hold_valid_r;
        overrun_nxt = 1'b0;
        if (hold_valid_r && fifo_ready_w) begin
            hold_valid_nxt = 1'b0;
        end
        if (state_r != UARX_ST_IDLE && tick_w) begin
            samp_nxt = n_w;
            if (n_w == vfirst_w || n_w == vfirst_w + `UARX_VOTE_MID) begin
                vote_nxt = {vote_r[0], rxd_s_r};
            end
        end
        case (state_r)
            UARX_ST_IDLE: begin
                if (start_det_w) begin
                    state_nxt = UARX_ST_START;
                    samp_nxt = `UARX_FIRST_SAMPLE;
                    bitcnt_nxt = '0;
                    shreg_nxt = '0;
                end
            end
            UARX_ST_START: begin
                if (vote_pt_w && maj_w) begin
                    state_nxt = UARX_ST_IDLE;
                end else if (wrap_w) begin
                    state_nxt = UARX_ST_DATA;
                end
            end
            UARX_ST_DATA: begin
                if (vote_pt_w) begin
                    shreg_nxt[bitcnt_r] = maj_w;
                    bitcnt_nxt = bitcnt_r + 1'b1;
                end else if (wrap_w && bitcnt_r >= i_frame_bits) begin
                    state_nxt = UARX_ST_STOP;
                end
            end
            UARX_ST_STOP: begin
                if (vote_pt_w) begin
                    state_nxt = UARX_ST_IDLE;
                    if (!hold_valid_nxt) begin
                        hold_valid_nxt = 1'b1;
                        hold_nxt.data = shreg_r;
                        hold_nxt.frame_err = !maj_w;
                    end else begin
                        overrun_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = UARX_ST_IDLE;
            end
        endcase
        if (!i_receiver_on) begin
            state_nxt = UARX_ST_IDLE;
            div_nxt = i_baud_divisor;
            samp_nxt = '0;
            last_nxt = 1'b0;
            hold_valid_nxt = 1'b0;
            overrun_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= UARX_ST_IDLE;
            div_r <= '0;
            samp_r <= '0;
            vote_r <= '0;
            last_r <= 1'b0;
            bitcnt_r <= '0;
            shreg_r <= '0;
            hold_r <= '0;
            hold_valid_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            samp_r <= samp_nxt;
            vote_r <= vote_nxt;
            last_r <= last_nxt;
            bitcnt_r <= bitcnt_nxt;
            shreg_r <= shreg_nxt;
            hold_r <= hold_nxt;
            hold_valid_r <= hold_valid_nxt;
            overrun_r <= overrun_nxt;
        end
    end

    // Character buffer; a full buffer stalls the hold register
    uarx_fifo #(
        .WIDTH($bits(uarx_char_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_flush(!i_receiver_on),
        .i_in_valid(hold_valid_r),
        .o_in_ready(fifo_ready_w),
        .i_in_data(hold_r),
        .o_out_valid(o_rx_complete_flag),
        .i_out_ready(i_rx_read),
        .o_out_data(fifo_out_w)
    );

    assign o_rx_data_location = fifo_out_w.data;
    assign o_frame_error_flag = fifo_out_w.frame_err;
    assign o_data_overrun = overrun_r;

    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_start_vote;
        state_r == UARX_ST_START && vote_pt_w;
    endsequence

    sequence s_stop_vote;
        state_r == UARX_ST_STOP && vote_pt_w;
    endsequence

    a_off_flushes: assert property (!i_receiver_on |=> !o_rx_complete_flag)
        else $error("buffer not empty after receiver off");

    a_off_aborts: assert property (!i_receiver_on |=> state_r == UARX_ST_IDLE && !hold_valid_r)
        else $error("reception not abandoned on receiver off");

    a_sync_depth: assert property (i_receiver_on ##0 1'b1 |-> rxd_s_r == $past(i_serial_receive_line, 2))
        else $error("receive line not delayed by two flops");

    a_sample_range: assert property (state_r != UARX_ST_IDLE |-> samp_r >= 5'h01 && samp_r <= spb_w)
        else $error("sample number outside bit");

    a_sample_hold: assert property (i_receiver_on && !tick_w && state_r != UARX_ST_IDLE |=> $stable(samp_r))
        else $error("sample advanced without baud tick");

    a_start_seen: assert property (start_det_w && i_receiver_on |=> state_r == UARX_ST_START && samp_r == 5'h01)
        else $error("start detection not begun at sample one");

    a_noise_reject: assert property (s_start_vote ##0 (maj_w && i_receiver_on) |=> state_r == UARX_ST_IDLE)
        else $error("noisy start not rejected");

    a_start_vote_pt: assert property (s_start_vote |-> samp_r == vfirst_w + 5'h01)
        else $error("start vote at wrong sample");

    a_data_vote: assert property (state_r == UARX_ST_DATA && vote_pt_w && i_receiver_on
        |=> shreg_r[$past(bitcnt_r)] == $past(maj_w))
        else $error("data bit not majority of samples");

    a_frame_err: assert property (s_stop_vote ##0 (!hold_valid_r && i_receiver_on)
        |=> hold_valid_r && hold_r.frame_err == !$past(maj_w))
        else $error("frame error not set from stop vote");

    a_early_start: assert property (s_stop_vote ##0 i_receiver_on |=> state_r == UARX_ST_IDLE)
        else $error("not ready for next start after stop vote");

    a_flag_set: assert property (hold_valid_r && fifo_ready_w && i_receiver_on |=> o_rx_complete_flag)
        else $error("complete flag low with buffered data");

    sequence s_last_wrap;
        state_r == UARX_ST_DATA && wrap_w && bitcnt_r >= i_frame_bits;
    endsequence

    a_stop_entry: assert property (s_last_wrap ##0 i_receiver_on |=> state_r == UARX_ST_STOP)
        else $error("stop bit not entered after last data bit");

    a_start_accept: assert property (s_start_vote ##0 (!maj_w && i_receiver_on) |=> state_r == UARX_ST_START)
        else $error("valid start bit dropped");

    a_frame_clear: assert property (start_det_w && i_receiver_on |=> shreg_r == '0 && bitcnt_r == '0)
        else $error("frame state not restarted on start bit");

    a_bit_wrap: assert property (state_r != UARX_ST_IDLE && wrap_w && i_receiver_on |=> samp_r == 5'h01)
        else $error("sample number not wrapped at bit end");

    a_vote_shift: assert property (state_r != UARX_ST_IDLE && tick_w && i_receiver_on && n_w == vfirst_w
        |=> vote_r[0] == $past(rxd_s_r))
        else $error("first voting sample not captured");

    a_div_reload: assert property (i_receiver_on && tick_w |=> div_r == $past(i_baud_divisor))
        else $error("baud divider not reloaded on tick");

    a_div_count: assert property (i_receiver_on && !tick_w |=> div_r == $past(div_r) - 1'b1)
        else $error("baud divider not counting down");

    a_hold_drain: assert property (hold_valid_r && fifo_ready_w && !done_w |=> !hold_valid_r)
        else $error("held character not moved into buffer");

    a_empty_stays: assert property (!o_rx_complete_flag && !hold_valid_r |=> !o_rx_complete_flag)
        else $error("complete flag raised without data");

endmodule

`default_nettype wire

/* core/uarx_regs.svh */
// Constants for the asynchronous receive front end
`ifndef UARX_REGS_SVH
`define UARX_REGS_SVH

`define UARX_SPB_NORMAL 5'h10
`define UARX_SPB_DOUBLE 5'h08
`define UARX_VOTE_NORMAL 5'h08
`define UARX_VOTE_DOUBLE 5'h04
`define UARX_VOTE_MID 5'h01
`define UARX_VOTE_LAST 5'h02
`define UARX_FIRST_SAMPLE 5'h01
`define UARX_FIFO_DEPTH 16
`define UARX_FRAME_MAX 10
`define UARX_FRAME_MIN 5
`define UARX_DIV_W 12
`define UARX_BITCNT_W 4

`endif

/* core/uarx_pkg.sv */
// Types shared by the receive front end
`include "uarx_regs.svh"

package uarx_pkg;

    typedef enum logic [1:0] {
        UARX_ST_IDLE = 2'b00,
        UARX_ST_START = 2'b01,
        UARX_ST_DATA = 2'b10,
        UARX_ST_STOP = 2'b11
    } uarx_state_t;

    typedef struct packed {
        logic frame_err;
        logic [`UARX_FRAME_MAX-1:0] data;
    } uarx_char_t;

endpackage

/* core/uarx_fifo.sv */
// Receive character FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
`default_nettype none

module uarx_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("uarx_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push_w;
    logic pop_w;

    assign o_in_ready = (cnt_r != DEPTH[AW:0]);
    assign o_out_valid = (cnt_r != '0);
    assign o_out_data = mem_r[rd_ptr_r];
    assign push_w = i_in_valid && o_in_ready && !i_flush;
    assign pop_w = o_out_valid && i_out_ready && !i_flush;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt = cnt_r;
        if (i_flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (push_w) begin
                wr_ptr_nxt = wr_ptr_r + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_nxt = rd_ptr_r + 1'b1;
            end
            if (push_w && !pop_w) begin
                cnt_nxt = cnt_r + 1'b1;
            end else if (pop_w && !push_w) begin
                cnt_nxt = cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage array, written only on an accepted push
    always_ff @(posedge i_ref_clk) begin
        if (push_w) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

endmodule

`default_nettype wire

/* verification/uarx_tx_model.sv */
// Remote serial transmitter model driving the receive line
`timescale 1ns/10ps
`default_nettype none

module uarx_tx_model (
    input wire logic i_ref_clk,
    output logic o_line
);
    initial o_line = 1'b1;

    // Start, bits LSB first, stop; bit length exact in clocks
    task automatic send(input logic [9:0] d, input int nb, input logic stp, input int bclk, input int sclk);
        int i;
        @(negedge i_ref_clk);
        o_line = 1'b0;
        repeat (bclk) @(negedge i_ref_clk);
        for (i = 0; i < nb; i++) begin
            o_line = d[i];
            repeat (bclk) @(negedge i_ref_clk);
        end
        o_line = stp;
        repeat (sclk) @(negedge i_ref_clk);
        o_line = 1'b1;
    endtask

    // Short low pulse on an idle line
    task automatic spike(input int clks);
        @(negedge i_ref_clk);
        o_line = 1'b0;
        repeat (clks) @(negedge i_ref_clk);
        o_line = 1'b1;
    endtask
endmodule

`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the receive front end
`timescale 1ns/10ps
`default_nettype none
`include "uarx_regs.svh"

module tb_top
    import uarx_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic rx_on = 1'b1;
    logic dbl = 1'b0;
    logic [`UARX_DIV_W-1:0] div = 12'h001;
    logic [`UARX_BITCNT_W-1:0] nbits = 4'h8;
    logic rd = 1'b0;
    logic line;
    logic [`UARX_FRAME_MAX-1:0] rdata;
    logic fe;
    logic flag;
    logic ovr;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    int ovr_seen = 0;

    uarx_tx_model u_tx (.i_ref_clk(ref_clk), .o_line(line));

    uarx_receiver #(.FIFO_DEPTH(16)) DUT (
        .i_ref_clk(ref_clk),
        .i_reset_n(reset_n),
        .i_serial_receive_line(line),
        .i_receiver_on(rx_on),
        .i_double_speed_select(dbl),
        .i_baud_divisor(div),
        .i_frame_bits(nbits),
        .i_rx_read(rd),
        .o_rx_data_location(rdata),
        .o_frame_error_flag(fe),
        .o_rx_complete_flag(flag),
        .o_data_overrun(ovr)
    );

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (ovr === 1'b1) ovr_seen <= ovr_seen + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            $display("BAD %0t timeout", $time);
            summarize();
        end
    end

    task automatic chk_char(input uarx_char_t got, input uarx_char_t exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t char got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic wait_flag(input int n);
        int i;
        for (i = 0; i < n && flag !== 1'b1; i++) @(negedge ref_clk);
    endtask

    // Checks the oldest character and pops it; read strobe is left high
    task automatic pop(input logic [9:0] d, input logic e);
        chk_bit(flag, 1'b1);
        chk_bit(fe, e);
        chk_char({fe, rdata}, {e, d});
        rd = 1'b1;
        @(negedge ref_clk);
    endtask

    task automatic t_basic();
        u_tx.send(10'h0a5, 8, 1'b1, 32, 32);
        wait_flag(200);
        pop(10'h0a5, 1'b0);
        rd = 1'b0;
        chk_bit(flag, 1'b0);
    endtask

    task automatic t_ferr_early();
        u_tx.send(10'h03c, 8, 1'b0, 32, 32);
        repeat (8) @(negedge ref_clk);
        u_tx.send(10'h05a, 8, 1'b1, 32, 24);
        u_tx.send(10'h081, 8, 1'b1, 32, 32);
        wait_flag(200);
        pop(10'h03c, 1'b1);
        pop(10'h05a, 1'b0);
        pop(10'h081, 1'b0);
        rd = 1'b0;
        chk_bit(flag, 1'b0);
    endtask

    task automatic t_double();
        int n;
        dbl = 1'b1;
        for (n = 5; n <= 10; n++) begin
            nbits = 4'(n);
            u_tx.send(10'h2c3, n, 1'b1, 16, 16);
            wait_flag(100);
            pop(10'h2c3 & 10'((1 << n) - 1), 1'b0);
            rd = 1'b0;
        end
        dbl = 1'b0;
        nbits = 4'h8;
    endtask

    task automatic t_noise();
        u_tx.spike(12);
        repeat (400) @(negedge ref_clk);
        chk_bit(flag, 1'b0);
        u_tx.send(10'h066, 8, 1'b1, 32, 32);
        wait_flag(200);
        pop(10'h066, 1'b0);
        rd = 1'b0;
    endtask

    task automatic t_abort();
        fork
            u_tx.send(10'h0ff, 8, 1'b1, 32, 32);
            begin
                repeat (100) @(negedge ref_clk);
                rx_on = 1'b0;
                @(negedge ref_clk);
                rx_on = 1'b1;
            end
        join
        repeat (100) @(negedge ref_clk);
        chk_bit(flag, 1'b0);
    endtask

    task automatic t_fill();
        int i;
        for (i = 0; i < 18; i++) u_tx.send(10'(i), 8, 1'b1, 32, 32);
        chk_bit(ovr_seen == 1, 1'b1);
        for (i = 0; i < 17; i++) pop(10'(i), 1'b0);
        rd = 1'b0;
        chk_bit(flag, 1'b0);
        u_tx.send(10'h011, 8, 1'b1, 32, 32);
        u_tx.send(10'h022, 8, 1'b1, 32, 32);
        wait_flag(50);
        chk_bit(flag, 1'b1);
        rx_on = 1'b0;
        @(negedge ref_clk);
        chk_bit(flag, 1'b0);
        rx_on = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk_bit(flag, 1'b0);
    endtask

    initial begin
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_basic();
        t_ferr_early();
        t_double();
        t_noise();
        t_abort();
        t_fill();
        summarize();
    end
endmodule

`default_nettype wire
